/* sbt_pkg.sv */
// Package: constants and types for the memory test access port
package sbt_pkg;

    typedef enum logic [3:0] {
        ST_RESET    = 4'b0000,
        ST_IDLE     = 4'b0001,
        ST_SEL_DR   = 4'b0010,
        ST_CAP_DR   = 4'b0011,
        ST_SH_DR    = 4'b0100,
        ST_EX1_DR   = 4'b0101,
        ST_PAU_DR   = 4'b0110,
        ST_EX2_DR   = 4'b0111,
        ST_UPD_DR   = 4'b1000,
        ST_SEL_IR   = 4'b1001,
        ST_CAP_IR   = 4'b1010,
        ST_SH_IR    = 4'b1011,
        ST_EX1_IR   = 4'b1100,
        ST_PAU_IR   = 4'b1101,
        ST_EX2_IR   = 4'b1110,
        ST_UPD_IR   = 4'b1111
    } sbt_state_t;

    localparam int          INSN_W        = 3;
    localparam logic [2:0]  INSN_EXTEST   = 3'h0;
    localparam logic [2:0]  INSN_IDCODE   = 3'h1;
    localparam logic [2:0]  INSN_SAMPLE_Z = 3'h2;
    localparam logic [2:0]  INSN_SAMPLE   = 3'h4;
    localparam logic [2:0]  INSN_BYPASS   = 3'h7;
    localparam logic [1:0]  IR_CAPTURE    = 2'h1;
    localparam int          ID_W          = 32;
    localparam int          SYNC_STAGES   = 3;
    localparam int          RESET_ONES    = 5;

endpackage : sbt_pkg

/* sbt_sync.sv */
// Three-stage input synchroniser with agreement check
module sbt_sync
    import sbt_pkg::*;
#(
    parameter logic INIT = 1'b1
) (
    input  wire logic CLK_I,
    input  wire logic RST_I,
    input  wire logic d_i,
    output logic      q_o
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            q_o <= INIT;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q_o <= s3;
            end
        end
    end
endmodule : sbt_sync

/* sbt_tap.sv */
// Top: test access port controller sampling the test clock on CLK_I
// Notes on behaviour
// - Inputs sampled on test clock rise
// - Outputs other than STATE_O change only on test clock fall; STATE_O follows the state on the rise
// - Mode-select steers the controller state machine
// - Undriven mode-select acts as one
// - Undriven data input acts as one
// - Selected register from state and instruction
// - Data in feeds selected register, out drives
// - Data output driven only while shifting
// - Five mode-select highs reach test-logic-reset
// - No separate asynchronous test reset input
// - Controller resets itself at power-up
// - No test clock keeps port idle
// - Follows the 1990 boundary scan standard
// - 3-bit instruction preloads identify on reset
// - Capture-IR loads 01 into low bits
// - New instruction takes effect at update-IR
// - Bypass is one bit, one stage
module sbt_tap
    import sbt_pkg::*;
#(
    parameter int             BSR_W   = 8,
    parameter logic [ID_W-1:0] ID_CODE = 32'h0000_0001 // Arbitrary value
) (
    input  wire logic             CLK_I,
    input  wire logic             RST_I,
    input  wire logic             TCK_I,
    input  wire logic             TMS_I,
    input  wire logic             TDI_I,
    input  wire logic [BSR_W-1:0] PINS_I,
    output logic                  TDO_O,
    output logic                  TDO_OE_O,
    output logic [BSR_W-1:0]      BSR_OUT_O,
    output logic                  EXTEST_O,
    output logic [3:0]            STATE_O
);
    // The boundary shift slices the register, so it needs two cells
    if (BSR_W < 2) begin : g_bad_width
        $error("BSR_W must be at least 2");
    end

    logic             tck_s;
    logic             tms_s;
    logic             tdi_s;
    logic             tck_d;
    logic             rise;
    logic             fall;
    sbt_state_t       state;
    sbt_state_t       next_state;
    logic [INSN_W-1:0] ir_sh;
    logic [INSN_W-1:0] ir;
    logic [ID_W-1:0]  id_sh;
    logic             byp;
    logic [BSR_W-1:0] bsr;
    logic             sel_out;
    logic             shifting;
    logic [INSN_W-1:0] next_ir;
    localparam int     ONES_W = $clog2(RESET_ONES);
    logic [ONES_W-1:0] ones_cnt;

    // Pull-ups: all three inputs reset to one and float as one
    sbt_sync #(.INIT(1'b1)) u_tck (
        .CLK_I (CLK_I), .RST_I (RST_I), .d_i (TCK_I), .q_o (tck_s));
    sbt_sync #(.INIT(1'b1)) u_tms (
        .CLK_I (CLK_I), .RST_I (RST_I), .d_i (TMS_I), .q_o (tms_s));
    sbt_sync #(.INIT(1'b1)) u_tdi (
        .CLK_I (CLK_I), .RST_I (RST_I), .d_i (TDI_I), .q_o (tdi_s));

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tck_d <= 1'b1;
        end else begin
            tck_d <= tck_s;
        end
    end

    assign rise = tck_s & ~tck_d;
    assign fall = ~tck_s & tck_d;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_RESET:  next_state = tms_s ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms_s ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_state = tms_s ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_state = tms_s ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms_s ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms_s ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_state = tms_s ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_state = tms_s ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    // RST_I stands for power-up; there is no test reset pin
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state <= ST_RESET;
        end else if (rise) begin
            state <= next_state;
        end
    end

    // Instruction value that the next test clock fall applies
    always_comb begin
        if (state == ST_RESET) begin
            next_ir = INSN_IDCODE;
        end else if (state == ST_UPD_IR) begin
            next_ir = ir_sh;
        end else begin
            next_ir = ir;
        end
    end

    // Shifts on the rise; applies on the fall so outputs follow at once
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ir_sh <= INSN_IDCODE;
            ir    <= INSN_IDCODE;
        end else begin
            if (rise && state == ST_CAP_IR) begin
                ir_sh <= {ir_sh[INSN_W-1:2], IR_CAPTURE};
            end else if (rise && state == ST_SH_IR) begin
                ir_sh <= {tdi_s, ir_sh[INSN_W-1:1]};
            end
            if (fall) begin
                ir <= next_ir;
            end
        end
    end

    // Counts consecutive test clock rises with mode-select high
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ones_cnt <= '0;
        end else if (rise) begin
            if (!tms_s) begin
                ones_cnt <= '0;
            end else if (ones_cnt != ONES_W'(RESET_ONES - 1)) begin
                ones_cnt <= ones_cnt + 1'b1;
            end
        end
    end

    // Data registers
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            id_sh <= '0;
            byp   <= 1'b0;
            bsr   <= '0;
        end else if (rise) begin
            if (state == ST_CAP_DR) begin
                id_sh <= ID_CODE;
                byp   <= 1'b0;
                bsr   <= PINS_I;
            end else if (state == ST_SH_DR) begin
                unique case (ir)
                    INSN_IDCODE: id_sh <= {tdi_s, id_sh[ID_W-1:1]};
                    INSN_EXTEST, INSN_SAMPLE, INSN_SAMPLE_Z:
                        bsr <= {tdi_s, bsr[BSR_W-1:1]};
                    default: byp <= tdi_s;
                endcase
            end
        end
    end

    // Boundary outputs latch on the fall in update-DR, boundary selected
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            BSR_OUT_O <= '0;
        end else if (fall && state == ST_UPD_DR &&
                     (ir == INSN_EXTEST || ir == INSN_SAMPLE ||
                      ir == INSN_SAMPLE_Z)) begin
            BSR_OUT_O <= bsr;
        end
    end

    always_comb begin
        if (state == ST_SH_IR) begin
            sel_out = ir_sh[0];
        end else begin
            unique case (ir)
                INSN_IDCODE: sel_out = id_sh[0];
                INSN_EXTEST, INSN_SAMPLE, INSN_SAMPLE_Z: sel_out = bsr[0];
                default: sel_out = byp;
            endcase
        end
    end

    assign shifting = (state == ST_SH_IR) || (state == ST_SH_DR);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            TDO_O    <= 1'b0;
            TDO_OE_O <= 1'b0;
            EXTEST_O <= 1'b0;
        end else if (fall) begin
            TDO_O    <= shifting ? sel_out : 1'b0;
            TDO_OE_O <= shifting;
            EXTEST_O <= (next_ir == INSN_EXTEST);
        end
    end

    assign STATE_O = state;

    output_on_fall_a: assert property (@(posedge CLK_I)
        disable iff (RST_I) !fall |=> $stable(TDO_O) && $stable(TDO_OE_O)
            && $stable(EXTEST_O) && $stable(BSR_OUT_O))
        else $error("Outputs changed without a test clock fall");

    state_on_rise_a: assert property (@(posedge CLK_I)
        disable iff (RST_I) !rise |=> $stable(state))
        else $error("State moved without a test clock rise");

    five_ones_a: assert property (@(posedge CLK_I)
        disable iff (RST_I)
        (rise && tms_s && ones_cnt == ONES_W'(RESET_ONES - 1))
        |=> state == ST_RESET)
        else $error("Five mode-select highs did not reach reset");

    oe_shift_a: assert property (@(posedge CLK_I)
        disable iff (RST_I) (fall && !shifting) |=> !TDO_OE_O)
        else $error("TDO driven outside a shift state");

    ir_reset_a: assert property (@(posedge CLK_I)
        disable iff (RST_I) (fall && state == ST_RESET)
        |=> ir == INSN_IDCODE)
        else $error("Instruction not preset in reset state");

    capir_a: assert property (@(posedge CLK_I)
        disable iff (RST_I) (rise && state == ST_CAP_IR)
        |=> ir_sh[1:0] == IR_CAPTURE)
        else $error("Capture-IR did not load 01");

    ir_hold_a: assert property (@(posedge CLK_I)
        disable iff (RST_I) (state != ST_UPD_IR && state != ST_RESET)
        |=> $stable(ir))
        else $error("Instruction changed outside update");

    ir_update_a: assert property (@(posedge CLK_I)
        disable iff (RST_I) (fall && state == ST_UPD_IR)
        |=> ir == $past(ir_sh))
        else $error("Update-IR did not apply the shifted instruction");

    bypass_a: assert property (@(posedge CLK_I)
        disable iff (RST_I) (rise && state == ST_SH_DR && ir == INSN_BYPASS)
        |=> byp == $past(tdi_s))
        else $error("Bypass stage did not take TDI");

    tlr_a: assert property (@(posedge CLK_I)
        disable iff (RST_I) (rise && tms_s && state == ST_SEL_IR)
        |=> state == ST_RESET)
        else $error("Select-IR with TMS high missed reset");

endmodule : sbt_tap

/* sbt_host.sv */
// Board-side test controller model driving clock, mode and data lines
module sbt_host
    import sbt_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic tdo_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Lines rest at their pull-up level, the clock parks high
    initial begin
        tck_o = 1'b1;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // One test clock period: fall with new lines, rise, then sample out
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tck_o <= 1'b0;
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (4) @(posedge CLK_I);
        tck_o <= 1'b1;
        repeat (4) @(posedge CLK_I);
        tdo = tdo_i;
    endtask : step
endmodule : sbt_host

/* tb_top.sv */
// Self-checking bench for the memory test access port
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
    $display("BAD %0t got %h exp %h", $time, (a), (e)); end end

module tb_top
    import sbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [31:0] ID = 32'hA5C3_0F1B; // Arbitrary value
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        tdo;
    logic        tdo_oe;
    logic        extest;
    logic [7:0]  pins = 8'hC6;
    logic [7:0]  bsr_out;
    logic [3:0]  state;
    logic [31:0] got;
    int          bad_count = 0;
    int          checks = 0;

    always #12.5 clk = ~clk;

    sbt_host host (.CLK_I(clk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms),
                   .tdi_o(tdi));
    sbt_tap #(.BSR_W(8), .ID_CODE(ID)) dut (.CLK_I(clk), .RST_I(rst),
        .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .PINS_I(pins), .TDO_O(tdo),
        .TDO_OE_O(tdo_oe), .BSR_OUT_O(bsr_out), .EXTEST_O(extest),
        .STATE_O(state));

    // Walk n mode-select values, LSB first, data input left high
    task automatic walk(input logic [7:0] m, input int n);
        logic d;
        for (int i = 0; i < n; i++) host.step(m[i], 1'b1, d);
    endtask : walk

    // Shift n bits LSB first, leaving on the last; collects data out
    task automatic shift(input int n, input logic [31:0] din);
        logic d;
        got = '0;
        for (int i = 0; i < n; i++) begin
            host.step(i == n - 1, din[i], d);
            got[i] = d;
            `CHK(tdo_oe, 1'b1)
        end
    endtask : shift

    task automatic at(input sbt_state_t s);
        repeat (2) @(posedge clk);
        `CHK(state, s)
    endtask : at

    task automatic load_ir(input logic [2:0] code);
        walk(8'h03, 4);
        shift(3, {29'h0, code});
        `CHK(got[1:0], IR_CAPTURE)
        walk(8'h01, 2);
    endtask : load_ir

    task automatic t_quiet;
        repeat (20) @(posedge clk);
        `CHK(state, ST_RESET)
        `CHK(tdo_oe, 1'b0)
        `CHK(extest, 1'b0)
        $display("test quiet done");
    endtask : t_quiet

    task automatic t_ir;
        walk(8'h06, 5);
        at(ST_SH_IR);
        shift(3, {29'h0, INSN_EXTEST});
        `CHK(got[1:0], IR_CAPTURE)
        at(ST_EX1_IR);
        `CHK(extest, 1'b0)
        walk(8'h01, 2);
        at(ST_IDLE);
        `CHK(extest, 1'b1)
        `CHK(tdo_oe, 1'b0)
        $display("test instruction done");
    endtask : t_ir

    task automatic t_reset;
        walk(8'h01, 3);
        at(ST_SH_DR);
        walk(8'h0F, 4);
        at(ST_SEL_IR);
        walk(8'h01, 1);
        at(ST_RESET);
        walk(8'h00, 1);
        `CHK(extest, 1'b0)
        walk(8'h01, 3);
        shift(32, 32'h0000_0000);
        `CHK(got, ID)
        walk(8'h01, 2);
        $display("test reset done");
    endtask : t_reset

    task automatic t_bypass;
        load_ir(INSN_BYPASS);
        walk(8'h01, 3);
        shift(8, 32'h0000_00B4);
        `CHK(got[7:0], 8'h68)
        walk(8'h01, 2);
        $display("test bypass done");
    endtask : t_bypass

    task automatic t_sample;
        load_ir(INSN_SAMPLE);
        walk(8'h01, 3);
        shift(8, 32'h0000_005A);
        `CHK(got[7:0], pins)
        walk(8'h01, 2);
        `CHK(bsr_out, 8'h5A)
        $display("test sample done");
    endtask : t_sample

    task automatic tally_and_finish;
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_quiet();
        t_ir();
        t_reset();
        t_bypass();
        t_sample();
        tally_and_finish();
    end

    // Whole run takes about 21 us; give up well past that
    initial begin
        #200us;
        bad_count++;
        tally_and_finish();
    end
endmodule : tb_top
